// >>> cmpo_pkg.sv
// Constants shared by the comparator output control block
package cmpo_pkg;

    // ****************************************
    // Bus widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_CTL0 = 8'h00;
    localparam logic [7:0] ADDR_CTL1 = 8'h04;
    localparam logic [7:0] ADDR_SUMMARY = 8'h08;
    localparam logic [7:0] ADDR_FLAG = 8'h0C;
    localparam logic [7:0] ADDR_PORT = 8'h10;

    // ****************************************
    // Control 0 field positions
    // ****************************************
    localparam int C0_ENABLE = 7;
    localparam int C0_RESULT = 6;
    localparam int C0_PIN_OE = 5;
    localparam int C0_INVERT = 4;
    localparam int C0_SPEED = 2;
    localparam int C0_HYST = 1;
    localparam int C0_SYNC = 0;

    // ****************************************
    // Control 1 field positions
    // ****************************************
    localparam int C1_RISE_EN = 7;
    localparam int C1_FALL_EN = 6;
    localparam int C1_PCH_LO = 4;
    localparam int C1_NCH_LO = 0;

    // ****************************************
    // Status field positions and resets
    // ****************************************
    localparam int SUM_OWN = 0;
    localparam int SUM_OTHER = 1;
    localparam int FLAG_BIT = 0;
    localparam int PORT_BIT = 0;
    localparam logic SPEED_RESET = 1'b1;

    // ****************************************
    // Positive channel codes
    // ****************************************
    localparam logic [1:0] PCH_PIN = 2'h0;
    localparam logic [1:0] PCH_DAC = 2'h1;
    localparam logic [1:0] PCH_FIXED = 2'h2;
    localparam logic [1:0] PCH_GROUND = 2'h3;

endpackage

// >>> cmpo_top.sv
// Digital control wrapper around one analog comparator
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module cmpo_top (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [cmpo_pkg::ADDR_W-1:0] addr_in,
    input wire logic [cmpo_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [cmpo_pkg::DATA_W-1:0] rdata_out,
    // Analog core
    input wire logic cmp_raw_in,
    output logic core_enable_out,
    output logic speed_out,
    output logic hyst_out,
    output logic [3:0] pos_sel_out,
    output logic [3:0] neg_sel_out,
    // Other comparator and timer
    input wire logic other_result_in,
    input wire logic timer_clk_in,
    output logic timer_gate_out,
    // Port pin
    input wire logic pin_dir_in,
    input wire logic analog_sel_in,
    input wire logic port_latch_in,
    input wire logic pin_in,
    output logic pin_data_out,
    output logic pin_oe_out,
    // Status
    output logic result_out,
    output logic irq_flag_out
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic raw_s1;
        logic raw_s2;
        logic tclk_s1;
        logic tclk_s2;
        logic tclk_prev;
        logic pin_s1;
        logic pin_s2;
        logic result;
        logic result_prev;
        logic sync_res;
        logic enable;
        logic pin_oe;
        logic invert;
        logic speed;
        logic hyst;
        logic sync_mode;
        logic rise_en;
        logic fall_en;
        logic [1:0] pch;
        logic [1:0] nch;
        logic irq_flag;
        logic [7:0] rdata;
    } cmpo_state_s;

    localparam cmpo_state_s ST_RESET = '{
        speed: cmpo_pkg::SPEED_RESET,
        default: '0
    };

    cmpo_state_s st;
    cmpo_state_s next_st;
    logic tclk_fall;
    logic rise;
    logic fall;
    logic set_flag;
    logic live_async;
    logic live;
    logic wr_ctl0;
    logic wr_ctl1;
    logic wr_flag;

    // ****************************************
    // Combinational helpers
    // ****************************************

    // Timer clock is only sampled, so its edge is seen a few cycles late
    assign tclk_fall = st.tclk_prev & ~st.tclk_s2;
    assign rise = st.result & ~st.result_prev;
    assign fall = ~st.result & st.result_prev;
    assign set_flag = (rise & st.rise_en) | (fall & st.fall_en);
    assign wr_ctl0 = wr_in && addr_in == cmpo_pkg::ADDR_CTL0;
    assign wr_ctl1 = wr_in && addr_in == cmpo_pkg::ADDR_CTL1;
    assign wr_flag = wr_in && addr_in == cmpo_pkg::ADDR_FLAG;

    // Unlatched path; raw input is glitchy, so use sync mode for the gate
    // Enable gates before polarity, so a disabled core still shows the invert bit
    assign live_async = (cmp_raw_in & st.enable) ^ st.invert;
    assign live = st.sync_mode ? st.sync_res : live_async;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        // Two-stage catchers for outside levels
        next_st.raw_s1 = cmp_raw_in;
        next_st.raw_s2 = st.raw_s1;
        next_st.tclk_s1 = timer_clk_in;
        next_st.tclk_s2 = st.tclk_s1;
        next_st.tclk_prev = st.tclk_s2;
        next_st.pin_s1 = pin_in;
        next_st.pin_s2 = st.pin_s1;
        // Polarity and enable applied before edge detection
        next_st.result = (st.raw_s2 & st.enable) ^ st.invert;
        next_st.result_prev = st.result;
        if (tclk_fall) begin
            next_st.sync_res = st.result;
        end
        // Control writes
        if (wr_ctl0) begin
            next_st.enable = wdata_in[cmpo_pkg::C0_ENABLE];
            next_st.pin_oe = wdata_in[cmpo_pkg::C0_PIN_OE];
            next_st.invert = wdata_in[cmpo_pkg::C0_INVERT];
            next_st.speed = wdata_in[cmpo_pkg::C0_SPEED];
            next_st.hyst = wdata_in[cmpo_pkg::C0_HYST];
            next_st.sync_mode = wdata_in[cmpo_pkg::C0_SYNC];
        end
        if (wr_ctl1) begin
            next_st.rise_en = wdata_in[cmpo_pkg::C1_RISE_EN];
            next_st.fall_en = wdata_in[cmpo_pkg::C1_FALL_EN];
            next_st.pch = wdata_in[cmpo_pkg::C1_PCH_LO +: 2];
            next_st.nch = wdata_in[cmpo_pkg::C1_NCH_LO +: 2];
        end
        // Flag is written directly; a new edge overrides a clear
        if (wr_flag) begin
            next_st.irq_flag = wdata_in[cmpo_pkg::FLAG_BIT];
        end
        if (set_flag) begin
            next_st.irq_flag = 1'b1;
        end
        // Read data stands only in the cycle after the strobe
        next_st.rdata = '0;
        if (rd_in) begin
            unique case (addr_in)
                cmpo_pkg::ADDR_CTL0: begin
                    next_st.rdata[cmpo_pkg::C0_ENABLE] = st.enable;
                    next_st.rdata[cmpo_pkg::C0_RESULT] = st.result;
                    next_st.rdata[cmpo_pkg::C0_PIN_OE] = st.pin_oe;
                    next_st.rdata[cmpo_pkg::C0_INVERT] = st.invert;
                    next_st.rdata[cmpo_pkg::C0_SPEED] = st.speed;
                    next_st.rdata[cmpo_pkg::C0_HYST] = st.hyst;
                    next_st.rdata[cmpo_pkg::C0_SYNC] = st.sync_mode;
                end
                cmpo_pkg::ADDR_CTL1: begin
                    next_st.rdata[cmpo_pkg::C1_RISE_EN] = st.rise_en;
                    next_st.rdata[cmpo_pkg::C1_FALL_EN] = st.fall_en;
                    next_st.rdata[cmpo_pkg::C1_PCH_LO +: 2] = st.pch;
                    next_st.rdata[cmpo_pkg::C1_NCH_LO +: 2] = st.nch;
                end
                cmpo_pkg::ADDR_SUMMARY: begin
                    next_st.rdata[cmpo_pkg::SUM_OWN] = st.result;
                    next_st.rdata[cmpo_pkg::SUM_OTHER] = other_result_in;
                end
                cmpo_pkg::ADDR_FLAG: begin
                    next_st.rdata[cmpo_pkg::FLAG_BIT] = st.irq_flag;
                end
                cmpo_pkg::ADDR_PORT: begin
                    // Analog pin reads low
                    next_st.rdata[cmpo_pkg::PORT_BIT] = st.pin_s2 & ~analog_sel_in;
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Input routing
    // ****************************************
    // One-hot selects; all off while disabled
    for (genvar i = 0; i < 4; i++) begin : g_sel
        assign pos_sel_out[i] = st.enable && st.pch == 2'(i);
        assign neg_sel_out[i] = st.enable && st.nch == 2'(i);
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_out = st.rdata;
    assign core_enable_out = st.enable;
    assign speed_out = st.speed;
    assign hyst_out = st.hyst;
    assign timer_gate_out = live;
    // Override ignores enable so the latch never leaks through
    assign pin_data_out = st.pin_oe ? live : port_latch_in;
    assign pin_oe_out = st.pin_oe & ~pin_dir_in & st.enable;
    assign result_out = st.result;
    assign irq_flag_out = st.irq_flag;

    // ****************************************
    // Assertions
    // ****************************************
    AST_READ_RESULT: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        rd_in && addr_in == cmpo_pkg::ADDR_CTL0
        |=> rdata_out[cmpo_pkg::C0_RESULT] == $past(st.result))
        else $error("Control 0 result bit wrong");

    AST_PIN_OFF: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (!st.enable || pin_dir_in || !st.pin_oe) |-> !pin_oe_out)
        else $error("Pin driven without all conditions");

    AST_LATCH_PASS: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !st.pin_oe |-> pin_data_out == port_latch_in)
        else $error("Port latch not passed");

    AST_RESULT_HIGH: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (st.enable && !st.invert && cmp_raw_in) [*4] |-> st.result)
        else $error("Result not high three cycles after input");

    AST_RESULT_INV: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (st.enable && st.invert && !cmp_raw_in) [*4] |-> st.result)
        else $error("Inverted result not high");

    AST_SPEED_RESET: assert property (
        @(posedge core_clk_in)
        $rose(reset_n_in) |-> speed_out && !st.rise_en && !st.fall_en)
        else $error("Reset values wrong");

    AST_HYST: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_ctl0 |=> hyst_out == $past(wdata_in[cmpo_pkg::C0_HYST]))
        else $error("Hysteresis does not follow bit");

    AST_SYNC_HOLD: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !tclk_fall |=> $stable(st.sync_res))
        else $error("Synchronised result moved off edge");

    AST_FLAG_SET: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        set_flag |=> irq_flag_out)
        else $error("Enabled edge did not set flag");

    AST_FLAG_HOLD: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        irq_flag_out && !wr_flag |=> irq_flag_out)
        else $error("Flag cleared by hardware");

    AST_INPUTS_OFF: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !st.enable |-> pos_sel_out == 4'h0 && neg_sel_out == 4'h0)
        else $error("Inputs connected while disabled");

    AST_PORT_READ: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        rd_in && addr_in == cmpo_pkg::ADDR_PORT && analog_sel_in
        |=> rdata_out == 8'h00)
        else $error("Analog pin read nonzero");

    AST_MIRROR: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        rd_in && addr_in == cmpo_pkg::ADDR_SUMMARY
        |=> rdata_out[7:2] == 6'h00
        && rdata_out[cmpo_pkg::SUM_OWN] == $past(st.result))
        else $error("Summary register wrong");

    // ****************************************
    // Further checks on paths the bench reaches rarely
    // ****************************************

    // Output enable hands the pin the live result
    AST_OVERRIDE: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        st.pin_oe |-> pin_data_out == live)
        else $error("Pin override does not carry result");

    // Gate follows the raw core at once when not synchronised
    AST_GATE_ASYNC: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !st.sync_mode |-> timer_gate_out == ((cmp_raw_in & st.enable) ^ st.invert))
        else $error("Unsynchronised gate not direct");

    // Capture takes the registered result at a detected timer fall
    AST_SYNC_CAPTURE: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        tclk_fall |=> st.sync_res == $past(st.result))
        else $error("Synchronised capture missed");

    // Ground code selects the last one-hot leg
    AST_POS_GROUND: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        st.enable && st.pch == cmpo_pkg::PCH_GROUND |-> pos_sel_out == 4'h8)
        else $error("Ground code not decoded");

    // Exactly one negative pin while the core is on
    AST_NEG_ONEHOT: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        st.enable |-> $onehot(neg_sel_out))
        else $error("Negative select not one-hot");

    // An edge in the clearing cycle keeps the flag
    AST_CLEAR_RACE: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_flag && set_flag |=> irq_flag_out)
        else $error("Edge lost during clear");

    // A clear with no edge really clears
    AST_FLAG_CLEAR: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_flag && !wdata_in[cmpo_pkg::FLAG_BIT] && !set_flag |=> !irq_flag_out)
        else $error("Flag not cleared by write");

    // Unused control 1 bits read low
    AST_CTL1_GAP: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        rd_in && addr_in == cmpo_pkg::ADDR_CTL1 |=> rdata_out[3:2] == 2'h0)
        else $error("Control 1 gap bits nonzero");

    // Speed select follows its written bit
    AST_SPEED_WRITE: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_ctl0 |=> speed_out == $past(wdata_in[cmpo_pkg::C0_SPEED]))
        else $error("Speed select not written");

    // Disabled core: result is the invert bit, so a flip makes an edge
    AST_OFF_POLARITY: assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !st.enable |=> st.result == $past(st.invert))
        else $error("Disabled result ignores polarity");

endmodule

// >>> cmpo_analog_model.sv
// Behavioural analog comparator core with its input multiplexers
`timescale 1ns/1ps
module cmpo_analog_model (
    // Clock and core controls
    input wire logic clk_in,
    input wire logic enable_in,
    input wire logic [3:0] pos_sel_in,
    input wire logic [3:0] neg_sel_in,
    // Node levels in arbitrary steps
    input wire logic [7:0] v_pin_in,
    input wire logic [7:0] v_dac_in,
    input wire logic [7:0] v_fixed_in,
    input wire logic [31:0] v_neg_in,
    output logic raw_out
);
    logic [7:0] vp;
    logic [7:0] vn;
    logic idle_q = 1'b0;
    // An unconnected core output wanders, so it must never look stable
    always @(posedge clk_in) idle_q <= ~idle_q;
    // Input multiplexers; the ground choice reads as level zero
    always_comb begin
        vp = 8'h00;
        vn = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (neg_sel_in[i]) vn = v_neg_in[8*i +: 8];
        end
        if (pos_sel_in[0]) vp = v_pin_in;
        if (pos_sel_in[1]) vp = v_dac_in;
        if (pos_sel_in[2]) vp = v_fixed_in;
    end
    // High when the positive node is above the negative one
    assign raw_out = (enable_in && |pos_sel_in && |neg_sel_in) ? (vp > vn) : idle_q;
endmodule

// >>> tb.sv
// Self-checking testbench for the comparator output control block
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic core_clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, rv, c0, c1;
    logic cmp_raw_in, core_enable_out, speed_out, hyst_out, timer_gate_out;
    logic [3:0] pos_sel_out, neg_sel_out;
    logic other_result_in = 1'b0, timer_clk_in = 1'b0, pin_dir_in = 1'b1, analog_sel_in = 1'b0;
    logic port_latch_in = 1'b0, pin_in = 1'b0, pin_data_out, pin_oe_out, result_out, irq_flag_out;
    logic [7:0] v_pin = 8'h40, v_dac = 8'h80, v_fix = 8'hC0;
    logic [31:0] v_neg = 32'h91513111;
    logic [1:0] p, n;
    logic er;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    integer seed = 32'hc9ca3c59;
    cmpo_top cmpo_top_inst (.core_clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .cmp_raw_in, .core_enable_out, .speed_out, .hyst_out, .pos_sel_out,
        .neg_sel_out, .other_result_in, .timer_clk_in, .timer_gate_out, .pin_dir_in,
        .analog_sel_in, .port_latch_in, .pin_in, .pin_data_out, .pin_oe_out, .result_out,
        .irq_flag_out);
    cmpo_analog_model cmpo_analog_model_inst (.clk_in(core_clk_in), .enable_in(core_enable_out),
        .pos_sel_in(pos_sel_out), .neg_sel_in(neg_sel_out), .v_pin_in(v_pin), .v_dac_in(v_dac),
        .v_fixed_in(v_fix), .v_neg_in(v_neg), .raw_out(cmp_raw_in));
    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    always #20 core_clk_in = ~core_clk_in;
    // A hang counts as a mismatch; the whole run needs well under 2000 cycles
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    // Raw core decision worked out from the bench's own node levels
    function automatic logic exp_raw(input logic [1:0] ps, input logic [1:0] ns);
        logic [7:0] vp;
        vp = (ps == cmpo_pkg::PCH_PIN) ? v_pin : (ps == cmpo_pkg::PCH_DAC) ? v_dac :
            (ps == cmpo_pkg::PCH_FIXED) ? v_fix : 8'h00;
        return vp > v_neg[8*ns +: 8];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        @(negedge core_clk_in);
        `CHK(rdata_out, e)
    endtask
    // Two-flop input sync plus result register need three edges
    task automatic settle();
        repeat (6) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask
    task automatic tick(input logic lvl);
        @(posedge core_clk_in);
        timer_clk_in <= lvl;
        settle();
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        chk_rd(cmpo_pkg::ADDR_CTL0, 8'h04);
        `CHK(speed_out, 1'b1)
        chk_rd(cmpo_pkg::ADDR_CTL1, 8'h00);
        chk_rd(cmpo_pkg::ADDR_FLAG, 8'h00);
        wr(cmpo_pkg::ADDR_SUMMARY, 8'hFF);
        wr(8'h14, 8'hFF);
        chk_rd(8'h14, 8'h00);
        chk_rd(cmpo_pkg::ADDR_SUMMARY, 8'h00);
        $display("test reset done");
        // Random settings; the first four walk every channel code with the core on
        for (int i = 0; i < 20; i++) begin
            p = $random(seed);
            n = $random(seed);
            c0 = $random(seed) & 8'hB6;
            if (i < 4) begin
                p = i;
                n = 3 - i;
                c0[7] = 1'b1;
            end
            c1 = {$random(seed)} & 8'hC0 | {2'b00, p, 2'b00, n};
            @(posedge core_clk_in);
            other_result_in <= $random(seed);
            pin_dir_in <= $random(seed);
            port_latch_in <= $random(seed);
            v_pin <= $random(seed) & 8'hFE;
            v_dac <= $random(seed) & 8'hFE;
            wr(cmpo_pkg::ADDR_CTL1, c1);
            wr(cmpo_pkg::ADDR_CTL0, c0);
            settle();
            er = (exp_raw(p, n) & c0[7]) ^ c0[4];
            `CHK(result_out, er)
            `CHK(pos_sel_out, c0[7] ? 4'h1 << p : 4'h0)
            `CHK(neg_sel_out, c0[7] ? 4'h1 << n : 4'h0)
            `CHK({core_enable_out, speed_out, hyst_out}, {c0[7], c0[2], c0[1]})
            `CHK(pin_oe_out, c0[5] & ~pin_dir_in & c0[7])
            `CHK(pin_data_out, c0[5] ? er : port_latch_in)
            `CHK(timer_gate_out, er)
            // Software checks the settled result before trusting it
            chk_rd(cmpo_pkg::ADDR_CTL0, c0 | {1'b0, er, 6'h00});
            chk_rd(cmpo_pkg::ADDR_SUMMARY, {6'h00, other_result_in, er});
            chk_rd(cmpo_pkg::ADDR_CTL1, c1);
        end
        $display("test random settings done");
        // Pin and gate follow the core at once while the result register lags
        wr(cmpo_pkg::ADDR_CTL1, 8'h00);
        wr(cmpo_pkg::ADDR_CTL0, 8'hA4);
        @(posedge core_clk_in);
        pin_dir_in <= 1'b0;
        v_pin <= 8'h40;
        settle();
        @(posedge core_clk_in);
        v_pin <= 8'h10;
        @(negedge core_clk_in);
        `CHK({timer_gate_out, pin_data_out, result_out}, 3'b001)
        $display("test unlatched path done");
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_in);
            analog_sel_in <= k[1];
            pin_in <= k[0];
            chk_rd(cmpo_pkg::ADDR_PORT, 8'h00);
            chk_rd(cmpo_pkg::ADDR_PORT, {7'h00, k[0] & ~k[1]});
        end
        $display("test port read done");
        // Edge flag: rise only, then fall only, then a polarity flip while off
        // Core on and edge enable set before the flag is cleared
        wr(cmpo_pkg::ADDR_CTL1, 8'h80);
        wr(cmpo_pkg::ADDR_FLAG, 8'h00);
        @(posedge core_clk_in);
        v_pin <= 8'h40;
        settle();
        `CHK(irq_flag_out, 1'b1)
        repeat (20) @(posedge core_clk_in);
        @(posedge core_clk_in);
        v_pin <= 8'h10;
        settle();
        `CHK(irq_flag_out, 1'b1)
        wr(cmpo_pkg::ADDR_FLAG, 8'h00);
        wr(cmpo_pkg::ADDR_CTL1, 8'h40);
        @(posedge core_clk_in);
        v_pin <= 8'h40;
        settle();
        `CHK(irq_flag_out, 1'b0)
        @(posedge core_clk_in);
        v_pin <= 8'h10;
        settle();
        chk_rd(cmpo_pkg::ADDR_FLAG, 8'h01);
        wr(cmpo_pkg::ADDR_CTL1, 8'h80);
        wr(cmpo_pkg::ADDR_CTL0, 8'h04);
        wr(cmpo_pkg::ADDR_FLAG, 8'h00);
        settle();
        wr(cmpo_pkg::ADDR_CTL0, 8'h14);
        settle();
        `CHK(irq_flag_out, 1'b1)
        $display("test edge flag done");
        // Synchronised mode: gate and pin move only at a timer clock fall
        wr(cmpo_pkg::ADDR_CTL0, 8'hA5);
        @(posedge core_clk_in);
        v_pin <= 8'h40;
        tick(1'b1);
        tick(1'b0);
        `CHK({timer_gate_out, pin_data_out}, 2'b11)
        @(posedge core_clk_in);
        v_pin <= 8'h10;
        settle();
        `CHK(timer_gate_out, 1'b1)
        tick(1'b1);
        `CHK(timer_gate_out, 1'b1)
        tick(1'b0);
        `CHK({timer_gate_out, pin_data_out}, 2'b00)
        $display("test sync mode done");
        conclude();
    end
endmodule
